/* File: hw/sar_adc_config_accumulator.sv */
`timescale 1ns/10ps
`default_nettype none

module sar_adc_config_accumulator
    import sar_adc_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input  wire logic              pclk,       // System clock, 125 MHz
    input  wire logic              presetn,    // Async reset, active low
    input  wire logic              psel,       // APB select
    input  wire logic              penable,    // APB access phase
    input  wire logic              pwrite,     // APB write
    input  wire logic [ADDR_W-1:0] paddr,      // APB byte address
    input  wire logic [31:0]       pwdata,     // APB write data
    input  wire logic [3:0]        pstrb,      // APB byte strobes
    output logic [31:0]            prdata,     // APB read data
    output logic                   pready,     // APB ready
    output logic                   pslverr,    // APB error, unmapped
    input  wire logic              lposc_tick, // Low-power oscillator enable
    input  wire logic              ext_start,  // Timer or pin start pulse
    input  wire logic              sar_done,   // Core result valid pulse
    input  wire logic [DATA_W-1:0] sar_data,   // Core result
    output sar_ctrl_t              sar_ctrl,   // Settings to the core
    output logic                   sar_start,  // Begin a conversion
    output logic                   conv_tick,  // Conversion clock enable
    output logic                   burst_mode_enable, // Burst mode active
    output logic                   busy        // Sequence in progress
);

    // ========
    // Register state
    // ========
    logic [7:0]  conv_cfg_q;
    logic [7:0]  acc_cfg_q;
    logic [7:0]  ctrl_q;
    logic [15:0] acc_q;
    logic        sar_start_q;
    logic [6:0]  remain_q;
    logic [1:0]  trk_q;
    state_t      state_q;
    state_t      state_d;

    // Decoded fields
    logic [4:0] conv_clock_divider;
    logic       eight_bit_enable;
    logic       delayed_track_select;
    logic       input_gain_select;
    logic       twelve_bit_enable;
    logic       accumulate_enable;
    logic [2:0] shift_justify_select;
    logic [2:0] burst_repeat_count;
    logic       conv_enable;
    logic [2:0] start_source_select;

    assign conv_clock_divider   = conv_cfg_q[CF_DIV_LSB +: 5];
    assign eight_bit_enable     = conv_cfg_q[CF_EIGHT];
    assign delayed_track_select = conv_cfg_q[CF_DTRACK];
    assign input_gain_select    = conv_cfg_q[CF_GAIN];
    assign twelve_bit_enable    = acc_cfg_q[AC_TWELVE];
    assign accumulate_enable    = acc_cfg_q[AC_ACCUM];
    assign shift_justify_select = acc_cfg_q[AC_SJ_LSB +: 3];
    assign burst_repeat_count   = acc_cfg_q[AC_RPT_LSB +: 3];
    assign conv_enable          = ctrl_q[CT_ENABLE];
    assign burst_mode_enable    = ctrl_q[CT_BURST];
    assign start_source_select  = ctrl_q[CT_MODE_LSB +: 3];

    // ========
    // Helper functions
    // ========
    // Conversions left to do after the first, per repeat code
    function automatic logic [6:0] extra_convs(input logic [2:0] code);
        logic [6:0] n;
        n = 7'd0;
        unique case (code)
            3'd1:    n = 7'd3;
            3'd2:    n = 7'd7;
            3'd3:    n = 7'd15;
            3'd4:    n = 7'd31;
            3'd5:    n = 7'd63;
            default: n = 7'd0;
        endcase
        return n;
    endfunction

    // Read format of the accumulator
    function automatic logic [15:0] fmt(input logic [15:0] a,
                                        input logic [2:0] sj,
                                        input res_t r);
        logic [15:0] v;
        v = a;
        unique case (sj)
            3'd0:    v = a;
            3'd1:    v = {1'b0, a[15:1]};
            3'd2:    v = {2'b00, a[15:2]};
            3'd3:    v = {3'b000, a[15:3]};
            SJ_LEFT: begin
                unique case (r)
                    RES_8:   v = {a[7:0], 8'h00};
                    RES_12:  v = {a[11:0], 4'h0};
                    default: v = {a[9:0], 6'h00};
                endcase
            end
            default: v = a;
        endcase
        return v;
    endfunction

    // ========
    // APB decode
    // ========
    logic       acc_w;
    logic       rd_en;
    logic       sel_acc_cfg;
    logic       sel_conv_cfg;
    logic       sel_lo;
    logic       sel_hi;
    logic       sel_ctrl;
    logic       mapped;
    logic       wr;
    logic [7:0] wbyte;

    assign acc_w        = psel && penable;
    assign sel_acc_cfg  = (paddr == {2'b00, IDX_ACC_CFG, 2'b00});
    assign sel_conv_cfg = (paddr == {2'b00, IDX_CONV_CFG, 2'b00});
    assign sel_lo       = (paddr == {2'b00, IDX_RES_LO, 2'b00});
    assign sel_hi       = (paddr == {2'b00, IDX_RES_HI, 2'b00});
    assign sel_ctrl     = (paddr == {2'b00, IDX_CTRL, 2'b00});
    assign mapped       = sel_acc_cfg | sel_conv_cfg | sel_lo | sel_hi | sel_ctrl;
    assign wr           = acc_w && pwrite && mapped && pstrb[0];
    assign wbyte        = pwdata[7:0];
    assign rd_en        = acc_w && !pwrite;
    assign pready       = 1'b1;
    assign pslverr      = acc_w && !mapped;

    // ========
    // Settings sent to the core
    // ========
    res_t res;

    // Twelve-bit enable overrides the eight-bit choice
    always_comb begin
        if (twelve_bit_enable) begin
            res = RES_12;
        end else if (eight_bit_enable) begin
            res = RES_8;
        end else begin
            res = RES_10;
        end
    end

    assign sar_ctrl.resolution = res;
    assign sar_ctrl.gain_unity = input_gain_select;
    assign sar_ctrl.tracking   = state_q != S_CONV;
    assign sar_start           = sar_start_q;
    assign busy                = state_q != S_IDLE;

    // ========
    // Conversion clock
    // ========
    logic div_src;

    // System clock every cycle, or oscillator ticks in burst mode
    assign div_src = burst_mode_enable ? lposc_tick : 1'b1;

    conv_clock_divider #(
        .DIV_W (5)
    ) u_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .src_tick (div_src),
        .divide   (conv_clock_divider),
        .tick     (conv_tick)
    );

    // ========
    // Control and configuration registers
    // ========
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_cfg_q <= CONV_CFG_RST;
            acc_cfg_q  <= ACC_CFG_RST;
            ctrl_q     <= CTRL_RST;
        end else if (wr) begin
            if (sel_conv_cfg) begin
                conv_cfg_q <= wbyte;
            end
            if (sel_acc_cfg) begin
                acc_cfg_q <= wbyte;
            end
            if (sel_ctrl) begin
                ctrl_q <= {wbyte[7:5], 1'b0, wbyte[3:0]};
            end
        end
    end

    // ========
    // Start of conversion
    // ========
    logic       start_req;
    logic       go;
    logic       ctl_wr;
    logic [2:0] new_mode;
    logic       burst_now;

    // A control write acts with the mode, enable and burst it carries
    assign ctl_wr    = wr && sel_ctrl;
    assign new_mode  = wbyte[CT_MODE_LSB +: 3];
    assign start_req = ctl_wr ? (wbyte[CT_BUSY] && new_mode == START_SW)
                     : (start_source_select != START_SW) && ext_start;
    assign go        = start_req && (ctl_wr ? wbyte[CT_ENABLE] : conv_enable);
    assign burst_now = ctl_wr ? wbyte[CT_BURST] : burst_mode_enable;

    // ========
    // Sequencer
    // ========
    logic trk_end;
    logic last_conv;

    assign trk_end   = conv_tick && (trk_q == TRACK_CLKS - 2'd1);
    assign last_conv = remain_q == 7'd0;

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (go) begin
                    state_d = delayed_track_select ? S_TRACK : S_CONV;
                end
            end
            S_TRACK: begin
                if (trk_end) begin
                    state_d = S_CONV;
                end
            end
            S_CONV: begin
                if (sar_done) begin
                    if (last_conv) begin
                        state_d = S_IDLE;
                    end else if (delayed_track_select) begin
                        state_d = S_TRACK;
                    end else begin
                        state_d = S_CONV;
                    end
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Start pulse on every entry into a conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_start_q <= 1'b0;
        end else begin
            sar_start_q <= (state_d == S_CONV)
                        && ((state_q != S_CONV) || sar_done);
        end
    end

    // Tracking delay counter in conversion clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trk_q <= 2'd0;
        end else if (state_q != S_TRACK) begin
            trk_q <= 2'd0;
        end else if (conv_tick) begin
            trk_q <= trk_q + 2'd1;
        end
    end

    // Conversions left in a burst
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain_q <= 7'd0;
        end else if (state_q == S_IDLE && go) begin
            remain_q <= burst_now ? extra_convs(burst_repeat_count) : 7'd0;
        end else if (state_q == S_CONV && sar_done && !last_conv) begin
            remain_q <= remain_q - 7'd1;
        end
    end

    // ========
    // Accumulator
    // ========
    logic [15:0] sample;
    logic        first;

    assign sample = 16'(sar_data);

    // First result of a burst replaces the old total
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first <= 1'b0;
        end else if (state_q == S_IDLE && go) begin
            first <= 1'b1;
        end else if (sar_done && state_q == S_CONV) begin
            first <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= ACC_RST;
        end else if (wr && sel_lo) begin
            acc_q[7:0] <= wbyte;
        end else if (wr && sel_hi) begin
            acc_q[15:8] <= wbyte;
        end else if (sar_done && state_q == S_CONV) begin
            if (burst_mode_enable) begin
                acc_q <= first ? sample : acc_q + sample;
            end else if (accumulate_enable) begin
                acc_q <= acc_q + sample;
            end else begin
                acc_q <= sample;
            end
        end
    end

    // ========
    // Read data
    // ========
    logic [15:0] shown;

    assign shown = fmt(acc_q, shift_justify_select, res);

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            unique case (1'b1)
                sel_conv_cfg: prdata[7:0] = conv_cfg_q;
                sel_acc_cfg:  prdata[7:0] = {acc_cfg_q[7], 1'b0, acc_cfg_q[5:0]};
                sel_lo:       prdata[7:0] = shown[7:0];
                sel_hi:       prdata[7:0] = shown[15:8];
                sel_ctrl:     prdata[7:0] = {ctrl_q[7:6], 1'b0, busy, 1'b0, ctrl_q[2:0]};
                default:      prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: hw/sar_adc_pkg.sv */
package sar_adc_pkg;

    // ========
    // Register indices (byte address is four times the index)
    // ========
    localparam logic [7:0]  IDX_ACC_CFG  = 8'hba;
    localparam logic [7:0]  IDX_CONV_CFG = 8'hbc;
    localparam logic [7:0]  IDX_RES_LO   = 8'hbd;
    localparam logic [7:0]  IDX_RES_HI   = 8'hbe;
    localparam logic [7:0]  IDX_CTRL     = 8'he8;
    localparam int          ADDR_W       = 12;

    // ========
    // Reset values
    // ========
    localparam logic [7:0]  CONV_CFG_RST = 8'hf8;
    localparam logic [7:0]  ACC_CFG_RST  = 8'h00;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [15:0] ACC_RST      = 16'h0000;

    // ========
    // Field positions
    // ========
    localparam int CF_DIV_LSB   = 3;
    localparam int CF_EIGHT     = 2;
    localparam int CF_DTRACK    = 1;
    localparam int CF_GAIN      = 0;
    localparam int AC_TWELVE    = 7;
    localparam int AC_ACCUM     = 6;
    localparam int AC_SJ_LSB    = 3;
    localparam int AC_RPT_LSB   = 0;
    localparam int CT_ENABLE    = 7;
    localparam int CT_BURST     = 6;
    localparam int CT_BUSY      = 4;
    localparam int CT_MODE_LSB  = 0;

    // ========
    // Counts and codes
    // ========
    localparam logic [1:0] TRACK_CLKS   = 2'd3;
    localparam logic [2:0] START_SW     = 3'b000;
    localparam logic [2:0] SJ_LEFT      = 3'b100;

    typedef enum logic [1:0] {
        RES_10 = 2'b00,
        RES_8  = 2'b01,
        RES_12 = 2'b10
    } res_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_TRACK = 3'b010,
        S_CONV  = 3'b100
    } state_t;

    // Settings handed to the analog core
    typedef struct packed {
        res_t resolution;
        logic gain_unity;
        logic tracking;
    } sar_ctrl_t;

endpackage

/* File: hw/conv_clock_divider.sv */
`timescale 1ns/10ps
`default_nettype none

module conv_clock_divider
    import sar_adc_pkg::*;
#(
    parameter int DIV_W = 5
) (
    input  wire logic             pclk,      // System clock
    input  wire logic             presetn,   // Async reset, active low
    input  wire logic             src_tick,  // Source clock enable
    input  wire logic [DIV_W-1:0] divide,    // Divide by this plus one
    output logic                  tick       // Conversion clock enable
);

    logic [DIV_W-1:0] cnt_q;

    // ==========================================================
    // Count source ticks, pulse every divide+1 of them
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (src_tick) begin
            if (cnt_q >= divide) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // Pulse on the last source tick of a period
    assign tick = src_tick && (cnt_q >= divide);

endmodule

`default_nettype wire

/* File: verif/sar_adc_config_accumulator_props.sv */
`timescale 1ns/10ps
`default_nettype none

module sar_adc_config_accumulator_props
    import sar_adc_pkg::*;
(
    input wire logic              pclk,              // System clock
    input wire logic              presetn,           // Async reset, active low
    input wire logic              psel,              // APB select
    input wire logic              penable,           // APB access phase
    input wire logic              pwrite,            // APB write
    input wire logic [ADDR_W-1:0] paddr,             // APB byte address
    input wire logic [31:0]       pwdata,            // APB write data
    input wire logic [3:0]        pstrb,             // APB byte strobes
    input wire logic [31:0]       prdata,            // APB read data
    input wire logic              pready,            // APB ready
    input wire logic              pslverr,           // APB error
    input wire logic              sar_start,         // Begin a conversion
    input wire logic              conv_tick,         // Conversion clock enable
    input wire logic              burst_mode_enable, // Burst mode active
    input wire logic              busy               // Sequence in progress
);
    // ========
    // Decoded bus events
    // ========
    localparam logic [11:0] A_CT = {2'b00, IDX_CTRL, 2'b00};
    localparam logic [11:0] A_CF = {2'b00, IDX_CONV_CFG, 2'b00};
    localparam logic [11:0] A_AC = {2'b00, IDX_ACC_CFG, 2'b00};
    logic       acc;
    logic       mapped;
    logic       wr_ct;
    logic       wr_cf;
    logic       sw_start;
    logic [4:0] div_q;
    logic       dtrack_q;
    logic [7:0] gap_q;
    logic       clean_q;
    assign acc      = psel && penable;
    assign mapped   = paddr == A_CT || paddr == A_CF || paddr == A_AC
                   || paddr == {2'b00, IDX_RES_LO, 2'b00} || paddr == {2'b00, IDX_RES_HI, 2'b00};
    assign wr_ct    = acc && pwrite && pstrb[0] && paddr == A_CT;
    assign wr_cf    = acc && pwrite && pstrb[0] && paddr == A_CF;
    assign sw_start = wr_ct && pwdata[7] && pwdata[4] && pwdata[2:0] == START_SW;

    // Shadow of divider and track mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q    <= 5'h1f;
            dtrack_q <= 1'b0;
        end else if (wr_cf) begin
            div_q    <= pwdata[7:3];
            dtrack_q <= pwdata[1];
        end
    end

    // Cycles since last tick, valid after one clean tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q   <= 8'h00;
            clean_q <= 1'b0;
        end else begin
            gap_q   <= conv_tick ? 8'h00 : gap_q + 8'h01;
            clean_q <= (wr_cf || wr_ct) ? 1'b0 : (conv_tick ? 1'b1 : clean_q);
        end
    end

    // ========
    // Properties
    // ========
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_sw_start;
        sw_start && !busy;
    endsequence

    chk_ready_high: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    chk_err_map: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_acc_wonly: assert property (acc && !pwrite && paddr == A_AC |-> !prdata[6])
        else $error("accumulate enable bit read back as one");
    chk_start_pulse: assert property (sar_start |=> !sar_start)
        else $error("start pulse longer than one cycle");
    chk_start_busy: assert property (sar_start |-> busy)
        else $error("start pulse while idle");
    chk_normal_start: assert property (s_sw_start ##0 !dtrack_q |=> sar_start)
        else $error("no start one cycle after busy-bit write");
    chk_delay_hold: assert property (s_sw_start ##0 dtrack_q |=> !sar_start [*3])
        else $error("delayed tracking started early");
    chk_burst_level: assert property (wr_ct |=> burst_mode_enable == $past(pwdata[6]))
        else $error("burst level differs from written bit");
    chk_tick_gap: assert property (conv_tick && clean_q && !burst_mode_enable
        |-> gap_q == {3'b000, div_q})
        else $error("conversion clock period wrong");
endmodule

bind sar_adc_config_accumulator sar_adc_config_accumulator_props props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sar_start(sar_start), .conv_tick(conv_tick),
    .burst_mode_enable(burst_mode_enable), .busy(busy));

`default_nettype wire

/* File: verif/sar_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

module sar_core_model
    import sar_adc_pkg::*;
(
    input  wire logic        pclk,      // System clock
    input  wire logic        presetn,   // Async reset, active low
    input  wire logic        sar_start, // Begin a conversion
    input  wire sar_ctrl_t   sar_ctrl,  // Resolution and gain
    input  wire logic [11:0] sample,    // Level to convert
    input  wire logic [3:0]  lag,       // Conversion length in cycles
    output logic             sar_done,  // Result valid pulse
    output logic [11:0]      sar_data   // Result, scrambled when idle
);
    logic [4:0]  cnt_q;
    logic [11:0] last_q;
    logic [11:0] mask;

    // ==========================================================
    // Result width follows the selected resolution
    // ==========================================================
    always_comb begin
        case (sar_ctrl.resolution)
            RES_8:   mask = 12'h0ff;
            RES_10:  mask = 12'h3ff;
            default: mask = 12'hfff;
        endcase
    end

    // Conversion timer, a result only ever follows a start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q    <= 5'h00;
            last_q   <= 12'h000;
            sar_done <= 1'b0;
        end else begin
            sar_done <= 1'b0;
            if (sar_start) begin
                cnt_q <= {1'b0, lag} + 5'h01;
            end else if (cnt_q == 5'h01) begin
                sar_done <= 1'b1;
                last_q   <= sample & mask;
                cnt_q    <= 5'h00;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end

    // Data lines show garbage outside the valid cycle
    assign sar_data = sar_done ? last_q : ~last_q;
endmodule

`default_nettype wire

/* File: verif/tb_sar_adc_config_accumulator.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_sar_adc_config_accumulator;
    import sar_adc_pkg::*;
    localparam logic [11:0] A_AC = {2'b00, IDX_ACC_CFG, 2'b00};
    localparam logic [11:0] A_CF = {2'b00, IDX_CONV_CFG, 2'b00};
    localparam logic [11:0] A_LO = {2'b00, IDX_RES_LO, 2'b00};
    localparam logic [11:0] A_HI = {2'b00, IDX_RES_HI, 2'b00};
    localparam logic [11:0] A_CT = {2'b00, IDX_CTRL, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lposc_tick;
    logic        sar_done, sar_start, conv_tick, burst_mode_enable, busy, lp_run;
    logic [11:0] paddr, sar_data, sample;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, lag, strb;
    logic [1:0]  lp_div;
    logic [15:0] accv, expv;
    sar_ctrl_t   sar_ctrl;
    int          n_fail, n_checks, n_tick, n_done, trk_n, trk_seen, cyc;
    int          reps[7] = '{1, 4, 8, 16, 32, 64, 1};
    logic [7:0]  t_cf[3] = '{8'h05, 8'h05, 8'h00};
    logic [7:0]  t_ac[3] = '{8'h00, 8'h80, 8'h00};
    res_t        t_res[3] = '{RES_8, RES_12, RES_10};

    sar_adc_config_accumulator uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lposc_tick(lposc_tick),
        .ext_start(1'b0), .sar_done(sar_done), .sar_data(sar_data), .sar_ctrl(sar_ctrl),
        .sar_start(sar_start), .conv_tick(conv_tick),
        .burst_mode_enable(burst_mode_enable), .busy(busy));
    sar_core_model core (.pclk(pclk), .presetn(presetn), .sar_start(sar_start),
        .sar_ctrl(sar_ctrl), .sample(sample), .lag(lag), .sar_done(sar_done),
        .sar_data(sar_data));

    // ========
    // Clock, oscillator ticks, monitors, timeout
    // ========
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        lp_div     <= lp_div + 2'd1;
        lposc_tick <= lp_run && lp_div == 2'd3;
        n_tick     = n_tick + int'(conv_tick);
        n_done     = n_done + int'(sar_done);
        if (sar_start) begin
            trk_seen = trk_n;
            trk_n    = 0;
        end else if (sar_done || !busy) begin
            trk_n = 0;
        end else if (conv_tick) begin
            trk_n = trk_n + 1;
        end
        cyc = cyc + 1;
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            tally_and_finish();
        end
    end

    // ========
    // Tasks
    // ========
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
                       output logic [8:0] rd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, wd};
        pstrb   <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) n_fail = n_fail + 1;
        rd = {pslverr, prdata[7:0]};
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [8:0] rd;
        apb(1'b1, a, d, rd);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [8:0] exp);
        logic [8:0] rd;
        apb(1'b0, a, 8'h00, rd);
        check({7'h00, rd}, {7'h00, exp});
    endtask

    task automatic rdacc(input logic [15:0] exp);
        rdc(A_LO, {1'b0, exp[7:0]});
        rdc(A_HI, {1'b0, exp[15:8]});
    endtask

    // Start by control write, wait for the sequence to finish
    task automatic convert(input logic [11:0] d, input logic [7:0] ctl);
        int n;
        sample = d;
        wr(A_CT, ctl);
        n = 0;
        do begin
            @(negedge pclk);
            n = n + 1;
        end while (busy !== 1'b0 && n < 3000);
        if (n >= 3000) n_fail = n_fail + 1;
    endtask

    task automatic count_ticks(input int exp);
        @(negedge pclk);
        n_tick = 0;
        repeat (40) @(negedge pclk);
        check(16'(n_tick), 16'(exp));
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ========
    // Main sequence
    // ========
    initial begin
        {pclk, presetn, psel, penable, pwrite, lposc_tick, lp_run} = '0;
        {paddr, pwdata, pstrb, sample, lp_div} = '0;
        {n_fail, n_checks, n_tick, n_done, trk_n, trk_seen, cyc} = '0;
        strb = 4'h1;
        lag  = 4'h2;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(A_CF, 9'h0f8);
        rdc(A_AC, 9'h000);
        rdc(A_CT, 9'h000);
        rdacc(16'h0000);
        rdc(12'h004, 9'h100);
        strb = 4'h0;
        wr(A_CF, 8'h55);
        strb = 4'h1;
        rdc(A_CF, 9'h0f8);
        for (int i = 0; i < 3; i++) begin
            wr(A_CF, t_cf[i]);
            wr(A_AC, t_ac[i]);
            @(negedge pclk);
            check(16'(sar_ctrl), 16'({t_res[i], t_cf[i][0], 1'b1}));
        end
        wr(A_CF, 8'h08);
        wr(A_AC, 8'h80);
        convert(12'habc, 8'h90);
        check(16'(trk_seen), 16'd0);
        convert(12'h123, 8'h90);
        rdacc(16'h0123);
        wr(A_AC, 8'hc0);
        rdc(A_AC, 9'h080);
        convert(12'h0ff, 8'h90);
        rdacc(16'h0222);
        wr(A_LO, 8'h00);
        wr(A_HI, 8'h00);
        rdacc(16'h0000);
        accv = 16'hb75c;
        wr(A_HI, accv[15:8]);
        wr(A_LO, accv[7:0]);
        for (int i = 0; i < 8; i++) begin
            wr(A_AC, 8'h80 | 8'(i << 3));
            expv = (i < 4) ? accv >> i : ((i == 4) ? accv << 4 : accv);
            rdacc(expv);
        end
        wr(A_AC, 8'h80);
        rdacc(accv);
        wr(A_CF, 8'h0a);
        convert(12'h001, 8'h90);
        check(16'(trk_seen), 16'd3);
        wr(A_CF, 8'h18);
        wr(A_CT, 8'h80);
        count_ticks(10);
        wr(A_CT, 8'hc0);
        rdc(A_CT, 9'h0c0);
        wr(A_CF, 8'h00);
        count_ticks(0);
        lp_run = 1'b1;
        count_ticks(10);
        for (int c = 0; c < 7; c++) begin
            wr(A_AC, 8'h80 | 8'(c));
            n_done = 0;
            convert(12'h105, 8'hd0);
            check(16'(n_done), 16'(reps[c]));
            rdacc(16'(reps[c] * 12'h105));
        end
        wr(A_CT, 8'h80);
        wr(A_AC, 8'h80);
        check({15'h0000, burst_mode_enable}, 16'h0000);
        tally_and_finish();
    end
endmodule

`default_nettype wire
